// >>> hw/taf_defs.vh
// Constants for the tag feature-word command interpreter
`ifndef TAF_DEFS_VH
`define TAF_DEFS_VH

// Toggle command coding
`define TAF_OPC_TOGGLE 16'hE007
`define TAF_RFU_ZERO 8'h00
// Feature word placement in the EPC bank
`define TAF_BANK_EPC 2'h1
`define TAF_FW_ADDR 16'h0200
`define TAF_ALARM_ADDR 16'h020F
`define TAF_FW_RESET 16'h0000
`define TAF_FW_WRITABLE 16'h0001
`define TAF_ALARM_BIT 0
// Protocol states reported by the surrounding tag state machine
`define TAF_ST_READY 3'h0
`define TAF_ST_ARB 3'h1
`define TAF_ST_REPLY 3'h2
`define TAF_ST_ACK 3'h3
`define TAF_ST_OPEN 3'h4
`define TAF_ST_SECURED 3'h5
`define TAF_ST_KILLED 3'h6
// Side limits on standard commands
`define TAF_BW_MAX_WORDS 8'h02
`define TAF_RECOM_ONLY 3'h4
// Error codes in the standard error reply
`define TAF_ERR_OTHER 8'h00
`define TAF_ERR_NONSPEC 8'h0F
// CRC-16 engine
`define TAF_CRC_POLY 16'h1021
`define TAF_CRC_PRESET 16'hFFFF
`define TAF_LEN_OK 6'h21
`define TAF_LEN_ERR 6'h19
// Timing
`define TAF_CLK_MHZ 10
`define TAF_REPLY_LIMIT_US 20000
`define TAF_CRC_MARGIN 64
`define TAF_WRITE_CYC 30000
`define TAF_BLANK_WRITE_CYC 10000

`endif

// >>> hw/taf_cycle_timer.v
// Down-counting cycle timer with a one-cycle expiry pulse
`timescale 1ns/1ns
`default_nettype none
module taf_cycle_timer #(
  parameter W = 18
) (
  input wire core_clk, // System clock
  input wire sys_rst, // Synchronous reset, active high
  input wire ce, // Clock enable
  input wire start, // Load and start counting
  input wire abort, // Stop without expiry
  input wire [W-1:0] load, // Cycles to run
  output reg done_ff, // Expiry pulse
  output reg busy_ff // Counting
);

  reg [W-1:0] cnt_ff;

  // Start wins over abort so a restart is never lost
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt_ff <= {W{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (ce)
    begin
      done_ff <= 1'b0;
      if (start)
      begin
        cnt_ff <= load;
        busy_ff <= 1'b1;
      end
      else if (abort)
        busy_ff <= 1'b0;
      else if (busy_ff)
      begin
        if (cnt_ff <= {{(W-1){1'b0}}, 1'b1})
        begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/taf_crc16_serial.v
// Bit-serial CRC-16 over up to 33 bits, MSB first
`timescale 1ns/1ns
`default_nettype none
`include "taf_defs.vh"
module taf_crc16_serial (
  input wire core_clk, // System clock
  input wire sys_rst, // Synchronous reset, active high
  input wire ce, // Clock enable
  input wire start, // Load data and begin
  input wire [32:0] data, // Bits, first bit at the top
  input wire [5:0] len, // Number of bits to cover
  output reg [15:0] crc_ff, // Finished CRC, ones complement
  output reg done_ff // Result valid pulse
);

  reg [32:0] shift_ff;
  reg [5:0] cnt_ff;
  reg [15:0] acc_ff;
  reg run_ff;
  wire fb;

  assign fb = acc_ff[15] ^ shift_ff[32];

  // One bit per cycle keeps the engine to a single register row
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      shift_ff <= 33'h000000000;
      cnt_ff <= 6'h00;
      acc_ff <= `TAF_CRC_PRESET;
      run_ff <= 1'b0;
      crc_ff <= 16'h0000;
      done_ff <= 1'b0;
    end
    else if (ce)
    begin
      done_ff <= 1'b0;
      if (start)
      begin
        shift_ff <= data;
        cnt_ff <= len;
        acc_ff <= `TAF_CRC_PRESET;
        run_ff <= 1'b1;
      end
      else if (run_ff)
      begin
        shift_ff <= {shift_ff[31:0], 1'b0};
        acc_ff <= {acc_ff[14:0], 1'b0} ^ (fb ? `TAF_CRC_POLY : 16'h0000);
        cnt_ff <= cnt_ff - 6'h01;
        if (cnt_ff == 6'h01)
        begin
          run_ff <= 1'b0;
          done_ff <= 1'b1;
          crc_ff <= ~({acc_ff[14:0], 1'b0} ^ (fb ? `TAF_CRC_POLY : 16'h0000));
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/taf_toggle_cmd.v
// Feature-word toggle command interpreter with alarm, USER_MEMORY_INDICATOR and side checks
`timescale 1ns/1ns
`default_nettype none
`include "taf_defs.vh"
module taf_toggle_cmd #(
  parameter WRITE_CYC = `TAF_WRITE_CYC,
  parameter BLANK_WRITE_CYC = `TAF_BLANK_WRITE_CYC,
  parameter REPLY_LIMIT_CYC = `TAF_REPLY_LIMIT_US * `TAF_CLK_MHZ
) (
  input wire core_clk, // System clock, 10 MHz
  input wire sys_rst, // Synchronous reset, active high
  input wire ce, // Clock enable, freezes all state when low
  input wire cmdValid, // Decoded command with good CRC, pulse
  input wire [15:0] cmdOpcode, // Command opcode
  input wire [7:0] cmdRfu, // Reserved field
  input wire [15:0] cmdData, // Toggle bits as received
  input wire [15:0] cmdCoverRn, // Cover-code random number
  input wire cmdCoverEn, // Toggle bits are cover-coded
  input wire [15:0] cmdHandle, // Handle carried by the command
  input wire [15:0] tagHandle, // Handle owned by the tag
  input wire [2:0] tagState, // Protocol state
  input wire accessPwdNonzero, // Stored access password is nonzero
  input wire nvmFault, // Nonvolatile write failed
  input wire rdReq, // Read request pulse
  input wire [1:0] rdBank, // Read bank
  input wire [15:0] rdBitAddr, // Read bit address
  input wire selReq, // Select request pulse
  input wire [1:0] selBank, // Select bank
  input wire [15:0] selPtr, // Select bit pointer
  input wire selMaskBit, // One-bit select mask
  input wire bwReq, // Block-write check pulse
  input wire [7:0] bwWordCount, // Block-write word count
  input wire killReq, // Recommission check pulse
  input wire [2:0] killRecom, // Recommission bits, MSB is the mandatory one
  input wire umiWr, // Reader writes the USER_MEMORY_INDICATOR bit, pulse
  input wire umiWrData, // USER_MEMORY_INDICATOR value to store
  output reg [15:0] featureWord_ff, // Stored feature control word
  output reg umiBit_ff, // Stored user-memory indicator
  output reg replyValid_ff, // Reply ready, pulse
  output reg replyErr_ff, // Reply is an error reply (header 1)
  output reg [15:0] replyStatus_ff, // Feature word, or error code in low byte
  output reg [15:0] replyHandle_ff, // Handle in the reply
  output reg [15:0] replyCrc_ff, // Reply CRC-16
  output reg toArbitrate_ff, // Tag must move to arbitrate, pulse
  output reg rdHit_ff, // Read addressed the feature word, pulse
  output reg [15:0] rdData_ff, // Read data
  output reg selHit_ff, // Select pointed at the alarm bit, pulse
  output reg selMatch_ff, // Alarm bit matched the mask
  output reg bwAccept_ff, // Block-write count accepted, pulse
  output reg bwReject_ff, // Block-write count refused, pulse
  output reg killAccept_ff, // Recommission accepted, pulse
  output reg killReject_ff, // Recommission refused, pulse
  output reg busy_ff // Toggle command in progress
);

  localparam S_IDLE = 3'b001;
  localparam S_WRITE = 3'b010;
  localparam S_CRC = 3'b100;
  // Counts are worked out at full width, then cut to the timer width on purpose
  localparam integer DEADLINE_FULL = REPLY_LIMIT_CYC - `TAF_CRC_MARGIN;
  localparam integer WRITE_FULL = WRITE_CYC;
  localparam integer BLANK_FULL = BLANK_WRITE_CYC;
  localparam [17:0] DEADLINE_LOAD = DEADLINE_FULL[17:0];
  localparam [17:0] WRITE_LOAD = WRITE_FULL[17:0];
  localparam [17:0] BLANK_LOAD = BLANK_FULL[17:0];

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [15:0] pendWord_ff;
  reg [15:0] nxt_pendWord;
  reg pendErr_ff;
  reg nxt_pendErr;
  reg [7:0] errCode_ff;
  reg [7:0] nxt_errCode;
  reg [15:0] nxt_featureWord;
  reg nxt_toArbitrate;
  reg [15:0] heldChange_ff;
  reg crcKick_ff;
  reg wrStart;
  reg wrAbort;
  reg [17:0] wrLoad;
  reg dlStart;
  wire [15:0] toggleBits;
  wire [15:0] changeBits;
  wire handleOk;
  wire isToggle;
  wire wrDone;
  wire dlDone;
  wire crcDone;
  wire [15:0] crcOut;
  wire [32:0] crcData;
  wire [5:0] crcLen;

  // Undo the optional cover code, then keep only the bits the tag may change
  assign toggleBits = cmdData ^ (cmdCoverEn ? cmdCoverRn : 16'h0000);
  assign changeBits = toggleBits & `TAF_FW_WRITABLE;
  assign handleOk = (cmdHandle == tagHandle);
  assign isToggle = cmdValid && (cmdOpcode == `TAF_OPC_TOGGLE);

  // Header, word, handle in order; an error reply carries code and handle
  assign crcData = pendErr_ff ? {1'b1, errCode_ff, tagHandle, 8'h00} : {1'b0, pendWord_ff, tagHandle};
  assign crcLen = pendErr_ff ? `TAF_LEN_ERR : `TAF_LEN_OK;

  // Nonvolatile write time
  taf_cycle_timer #(
    .W(18)
  ) uWriteTimer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(wrStart),
    .abort(wrAbort),
    .load(wrLoad),
    .done_ff(wrDone),
    .busy_ff()
  );

  // Reply deadline counted from the command
  taf_cycle_timer #(
    .W(18)
  ) uDeadline (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(dlStart),
    .abort(1'b0),
    .load(DEADLINE_LOAD),
    .done_ff(dlDone),
    .busy_ff()
  );

  taf_crc16_serial uCrc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(crcKick_ff),
    .data(crcData),
    .len(crcLen),
    .crc_ff(crcOut),
    .done_ff(crcDone)
  );

  // Toggle command sequencing
  always @*
  begin
    nxt_state = state_ff;
    nxt_pendWord = pendWord_ff;
    nxt_pendErr = pendErr_ff;
    nxt_errCode = errCode_ff;
    nxt_featureWord = featureWord_ff;
    nxt_toArbitrate = 1'b0;
    wrStart = 1'b0;
    wrAbort = 1'b0;
    wrLoad = WRITE_LOAD;
    dlStart = 1'b0;
    case (state_ff)
      S_IDLE:
      begin
        if (isToggle)
        begin
          nxt_pendWord = featureWord_ff;
          nxt_pendErr = 1'b0;
          if (tagState == `TAF_ST_ARB || tagState == `TAF_ST_REPLY || tagState == `TAF_ST_ACK)
            nxt_toArbitrate = 1'b1;
          else if (tagState == `TAF_ST_OPEN && handleOk)
          begin
            if (cmdRfu != `TAF_RFU_ZERO)
            begin
              nxt_pendErr = 1'b1;
              nxt_errCode = `TAF_ERR_OTHER;
            end
            // Open state never writes: unchanged word goes out at once
            nxt_state = S_CRC;
          end
          else if (tagState == `TAF_ST_SECURED && handleOk)
          begin
            if (cmdRfu != `TAF_RFU_ZERO)
            begin
              nxt_pendErr = 1'b1;
              nxt_errCode = `TAF_ERR_OTHER;
              nxt_state = S_CRC;
            end
            else if (changeBits != 16'h0000 && accessPwdNonzero)
            begin
              // A blank word takes the quicker write
              wrLoad = (featureWord_ff == 16'h0000) ? BLANK_LOAD : WRITE_LOAD;
              wrStart = 1'b1;
              dlStart = 1'b1;
              nxt_state = S_WRITE;
            end
            else
              nxt_state = S_CRC;
          end
          else if (tagState == `TAF_ST_SECURED)
            nxt_state = S_IDLE;
          // Ready, killed, or open with a wrong handle: nothing at all
        end
      end
      S_WRITE:
      begin
        if (wrDone)
        begin
          if (nvmFault)
          begin
            nxt_pendErr = 1'b1;
            nxt_errCode = `TAF_ERR_NONSPEC;
          end
          else
          begin
            nxt_featureWord = featureWord_ff ^ heldChange_ff;
            nxt_pendWord = nxt_featureWord;
          end
          nxt_state = S_CRC;
        end
        else if (dlDone)
        begin
          // Missing the deadline is reported instead of a late success
          wrAbort = 1'b1;
          nxt_pendErr = 1'b1;
          nxt_errCode = `TAF_ERR_NONSPEC;
          nxt_state = S_CRC;
        end
      end
      S_CRC:
      begin
        if (crcDone)
          nxt_state = S_IDLE;
      end
      default:
        nxt_state = S_IDLE;
    endcase
  end

  // Change mask is held through the write, as the command fields move on;
  // the CRC starts one cycle after the reply contents settle
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_ff <= S_IDLE;
      pendWord_ff <= `TAF_FW_RESET;
      pendErr_ff <= 1'b0;
      errCode_ff <= `TAF_ERR_OTHER;
      featureWord_ff <= `TAF_FW_RESET;
      heldChange_ff <= 16'h0000;
      crcKick_ff <= 1'b0;
      toArbitrate_ff <= 1'b0;
      replyValid_ff <= 1'b0;
      replyErr_ff <= 1'b0;
      replyStatus_ff <= 16'h0000;
      replyHandle_ff <= 16'h0000;
      replyCrc_ff <= 16'h0000;
      busy_ff <= 1'b0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      pendWord_ff <= nxt_pendWord;
      pendErr_ff <= nxt_pendErr;
      errCode_ff <= nxt_errCode;
      featureWord_ff <= nxt_featureWord;
      toArbitrate_ff <= nxt_toArbitrate;
      busy_ff <= (nxt_state != S_IDLE);
      if (wrStart)
        heldChange_ff <= changeBits;
      crcKick_ff <= (nxt_state == S_CRC) && (state_ff != S_CRC);
      replyValid_ff <= crcDone;
      if (crcDone)
      begin
        replyErr_ff <= pendErr_ff;
        replyStatus_ff <= pendErr_ff ? {8'h00, errCode_ff} : pendWord_ff;
        replyHandle_ff <= tagHandle;
        replyCrc_ff <= crcOut;
      end
    end
  end

  // Side checks on standard commands, read and select paths
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      umiBit_ff <= 1'b0;
      rdHit_ff <= 1'b0;
      rdData_ff <= 16'h0000;
      selHit_ff <= 1'b0;
      selMatch_ff <= 1'b0;
      bwAccept_ff <= 1'b0;
      bwReject_ff <= 1'b0;
      killAccept_ff <= 1'b0;
      killReject_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (umiWr)
        umiBit_ff <= umiWrData;
      rdHit_ff <= rdReq && rdBank == `TAF_BANK_EPC && rdBitAddr == `TAF_FW_ADDR;
      if (rdReq)
        rdData_ff <= featureWord_ff;
      selHit_ff <= selReq && selBank == `TAF_BANK_EPC && selPtr == `TAF_ALARM_ADDR;
      if (selReq)
        selMatch_ff <= featureWord_ff[`TAF_ALARM_BIT] == selMaskBit;
      bwAccept_ff <= bwReq && bwWordCount <= `TAF_BW_MAX_WORDS;
      bwReject_ff <= bwReq && bwWordCount > `TAF_BW_MAX_WORDS;
      killAccept_ff <= killReq && killRecom == `TAF_RECOM_ONLY;
      killReject_ff <= killReq && killRecom != `TAF_RECOM_ONLY;
    end
  end

endmodule
`default_nettype wire

// >>> verification/taf_toggle_props.sv
// Concurrent checks on the ports of the toggle command interpreter
`timescale 1ns/1ns
`default_nettype none
module taf_toggle_props (
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic ce, // Enable
  input wire logic cmdValid, // Command pulse
  input wire logic [15:0] cmdOpcode, // Opcode
  input wire logic [15:0] cmdHandle, // Command handle
  input wire logic [15:0] tagHandle, // Own handle
  input wire logic [2:0] tagState, // State
  input wire logic rdReq, // Read pulse
  input wire logic [1:0] rdBank, // Read bank
  input wire logic [15:0] rdBitAddr, // Read address
  input wire logic selReq, // Select pulse
  input wire logic [1:0] selBank, // Select bank
  input wire logic [15:0] selPtr, // Select pointer
  input wire logic selMaskBit, // Select mask
  input wire logic bwReq, // Block-write pulse
  input wire logic [7:0] bwWordCount, // Word count
  input wire logic killReq, // Kill pulse
  input wire logic [2:0] killRecom, // Recommission bits
  input wire logic umiWr, // USER_MEMORY_INDICATOR write
  input wire logic umiWrData, // USER_MEMORY_INDICATOR value
  input wire logic [15:0] featureWord_ff, // Feature word
  input wire logic umiBit_ff, // USER_MEMORY_INDICATOR bit
  input wire logic replyValid_ff, // Reply pulse
  input wire logic [15:0] replyHandle_ff, // Reply handle
  input wire logic toArbitrate_ff, // Arbitrate pulse
  input wire logic rdHit_ff, // Read hit
  input wire logic [15:0] rdData_ff, // Read data
  input wire logic selHit_ff, // Select hit
  input wire logic selMatch_ff, // Select match
  input wire logic bwAccept_ff, // Count accepted
  input wire logic bwReject_ff, // Count refused
  input wire logic killAccept_ff, // Kill accepted
  input wire logic killReject_ff, // Kill refused
  input wire logic busy_ff // Busy
);
  logic take;
  // A toggle command that the idle interpreter takes
  assign take = ce && cmdValid && cmdOpcode == 16'hE007 && !busy_ff;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  AST_BW_OK: assert property (ce && bwReq && bwWordCount <= 8'h02 |=> bwAccept_ff && !bwReject_ff)
    else $error("block-write count wrongly refused");
  AST_BW_BAD: assert property (ce && bwReq && bwWordCount > 8'h02 |=> bwReject_ff && !bwAccept_ff)
    else $error("block-write count wrongly accepted");
  AST_KILL: assert property (ce && killReq |=>
    (killAccept_ff == ($past(killRecom) == 3'h4)) && (killAccept_ff != killReject_ff))
    else $error("recommission decision wrong");
  AST_UMI: assert property (ce && umiWr |=> umiBit_ff == $past(umiWrData))
    else $error("user memory indicator not stored");
  AST_READ: assert property (ce && rdReq && rdBank == 2'h1 && rdBitAddr == 16'h0200 |=>
    rdHit_ff && rdData_ff == $past(featureWord_ff))
    else $error("feature word read wrong");
  AST_SEL: assert property (ce && selReq && selBank == 2'h1 && selPtr == 16'h020F |=>
    selHit_ff && selMatch_ff == ($past(featureWord_ff[0]) == $past(selMaskBit)))
    else $error("alarm select match wrong");
  // Only the alarm bit may move, and only inside a toggle command
  AST_ONLY_TOGGLE: assert property ($changed(featureWord_ff) |->
    $past(busy_ff) && (featureWord_ff ^ $past(featureWord_ff)) == 16'h0001)
    else $error("feature word changed outside a toggle");
  AST_ARB: assert property (take && tagState >= 3'h1 && tagState <= 3'h3 |=>
    toArbitrate_ff && !replyValid_ff ##1 !replyValid_ff [*8])
    else $error("arbitrate move missing or reply sent");
  AST_SILENT: assert property (take && (tagState == 3'h0 || tagState == 3'h6) |=>
    (!replyValid_ff && !toArbitrate_ff) [*8])
    else $error("ignored state gave output");
  AST_IMMED: assert property (take && tagState == 3'h4 && cmdHandle == tagHandle |-> ##[2:40] replyValid_ff)
    else $error("open-state reply late");
  AST_HANDLE: assert property (replyValid_ff |-> replyHandle_ff == tagHandle)
    else $error("reply handle wrong");
endmodule
bind taf_toggle_cmd taf_toggle_props uProps (.*);
`default_nettype wire

// >>> verification/taf_reader_model.sv
// Reader-side model that frames toggle, read, select and USER_MEMORY_INDICATOR-write requests
`timescale 1ns/1ns
`default_nettype none
module taf_reader_model (
  input wire logic core_clk, // Clock
  output logic cmdValid, // Command pulse
  output logic [15:0] cmdOpcode, // Opcode
  output logic [7:0] cmdRfu, // Reserved byte
  output logic [15:0] cmdData, // Toggle bits on air
  output logic [15:0] cmdCoverRn, // Cover number
  output logic cmdCoverEn, // Cover on
  output logic [15:0] cmdHandle, // Handle
  output logic rdReq, // Read pulse
  output logic [1:0] rdBank, // Read bank
  output logic [15:0] rdBitAddr, // Read address
  output logic selReq, // Select pulse
  output logic [1:0] selBank, // Select bank
  output logic [15:0] selPtr, // Select pointer
  output logic selMaskBit, // Select mask
  output logic umiWr, // USER_MEMORY_INDICATOR write pulse
  output logic umiWrData // USER_MEMORY_INDICATOR value
);
  // Quiet link at start
  initial
  begin
    {cmdValid, rdReq, selReq, umiWr} = 4'h0;
    {cmdOpcode, cmdRfu, cmdData, cmdCoverRn, cmdCoverEn, cmdHandle} = 73'h0;
    {rdBank, rdBitAddr, selBank, selPtr, selMaskBit, umiWrData} = 38'h0;
  end
  // Opcode, reserved byte, toggle bits (covered on request), handle
  task toggle(input logic [7:0] rfu, input logic [15:0] bits, input logic cov, input logic [15:0] h);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdOpcode <= 16'hE007;
    cmdRfu <= rfu;
    cmdCoverRn <= 16'hC3A5;
    cmdCoverEn <= cov;
    cmdData <= cov ? (bits ^ 16'hC3A5) : bits;
    cmdHandle <= h;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    // Stale toggle bits and handle are scrambled so nothing leans on their old value
    cmdData <= ~cmdData;
    cmdHandle <= ~cmdHandle;
  endtask
  // Alarm check: select EPC bank, pointer at the alarm bit, mask one
  task alarmCheck;
    @(posedge core_clk);
    selReq <= 1'b1;
    {selBank, selPtr, selMaskBit} <= {2'h1, 16'h020F, 1'b1};
    @(posedge core_clk);
    selReq <= 1'b0;
    selPtr <= ~selPtr;
  endtask
  // Plain read of the feature word address
  task readWord;
    @(posedge core_clk);
    rdReq <= 1'b1;
    {rdBank, rdBitAddr} <= {2'h1, 16'h0200};
    @(posedge core_clk);
    rdReq <= 1'b0;
    rdBitAddr <= ~rdBitAddr;
  endtask
  // Reader writes the user-memory indicator
  task user_memory_indicator(input logic v);
    @(posedge core_clk);
    umiWr <= 1'b1;
    umiWrData <= v;
    @(posedge core_clk);
    umiWr <= 1'b0;
    umiWrData <= ~v;
  endtask
endmodule
`default_nettype wire

// >>> verification/taf_toggle_cmd_tb.sv
// Self-checking bench for the feature-word toggle command interpreter
`timescale 1ns/1ns
`default_nettype none
module taf_toggle_cmd_tb;
  localparam int WCYC = 20;
  localparam int BCYC = 5;
  localparam logic [15:0] HND = 16'h5A3C;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [15:0] tagHandle = HND;
  logic [2:0] tagState = 3'h4;
  logic accessPwdNonzero = 1'b1;
  logic nvmFault = 1'b0;
  logic bwReq = 1'b0;
  logic [7:0] bwWordCount = 8'h00;
  logic killReq = 1'b0;
  logic [2:0] killRecom = 3'h0;
  logic cmdValid, cmdCoverEn, rdReq, selReq, selMaskBit, umiWr, umiWrData;
  logic [15:0] cmdOpcode, cmdData, cmdCoverRn, cmdHandle, rdBitAddr, selPtr;
  logic [7:0] cmdRfu;
  logic [1:0] rdBank, selBank;
  logic [15:0] featureWord_ff, replyStatus_ff, replyHandle_ff, replyCrc_ff, rdData_ff;
  logic umiBit_ff, replyValid_ff, replyErr_ff, toArbitrate_ff, rdHit_ff, selHit_ff, selMatch_ff;
  logic bwAccept_ff, bwReject_ff, killAccept_ff, killReject_ff, busy_ff;
  int errorCnt = 0;
  int comparisons = 0;
  int lat;
  int blank;
  logic sawArb;
  logic sawBusy;

  taf_toggle_cmd #(.WRITE_CYC(WCYC), .BLANK_WRITE_CYC(BCYC), .REPLY_LIMIT_CYC(400)) DUT (.*);
  taf_reader_model rdr (.*);

  // 10 MHz system clock
  always #50 core_clk = ~core_clk;

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Reference CRC-16: preset all ones, first bit at the top, result inverted
  function automatic logic [15:0] crc16(input logic [32:0] d, input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[32 - i]) ? 16'h1021 : 16'h0000);
    return ~c;
  endfunction

  // One toggle in a given state; the wait is bounded so a lost reply cannot hang
  task cmd(input logic [2:0] st, input logic [7:0] rfu, input logic [15:0] bits, input logic [15:0] h);
    @(posedge core_clk);
    tagState <= st;
    lat = 0;
    rdr.toggle(rfu, bits, st == 3'h5, h);
    #1;
    sawArb = (toArbitrate_ff === 1'b1);
    sawBusy = (busy_ff === 1'b1);
    for (int i = 1; i <= 80 && lat == 0; i++)
    begin
      @(posedge core_clk);
      #1;
      if (toArbitrate_ff === 1'b1) sawArb = 1'b1;
      if (replyValid_ff === 1'b1) lat = i;
    end
  endtask

  task chkReply(input logic err, input logic [15:0] st);
    logic [15:0] ex;
    ex = err ? crc16({1'b1, st[7:0], HND, 8'h00}, 25) : crc16({1'b0, st, HND}, 33);
    chk("reply seen", lat != 0, 1'b1);
    chk("reply header", replyErr_ff, err);
    chk("reply status", replyStatus_ff, st);
    chk("reply handle", replyHandle_ff, HND);
    chk("reply crc", replyCrc_ff, ex);
  endtask

  task tSide;
    for (int i = 0; i < 9; i++)
    begin
      @(posedge core_clk);
      bwReq <= 1'b1;
      bwWordCount <= (i == 8) ? 8'hFF : i[7:0];
      killReq <= 1'b1;
      killRecom <= i[2:0];
      @(posedge core_clk);
      bwReq <= 1'b0;
      killReq <= 1'b0;
      #1;
      chk("bw accept", bwAccept_ff, i <= 2);
      chk("bw reject", bwReject_ff, i > 2);
      chk("kill accept", killAccept_ff, i == 4);
      chk("kill reject", killReject_ff, i != 4);
    end
    rdr.user_memory_indicator(1'b1);
    #1;
    chk("umi set", umiBit_ff, 1'b1);
    rdr.user_memory_indicator(1'b0);
    #1;
    chk("umi clear", umiBit_ff, 1'b0);
    $display("test side limits done");
  endtask

  task tOpen;
    cmd(3'h4, 8'h00, 16'h0001, HND);
    chkReply(1'b0, 16'h0000);
    chk("open reply fast", lat <= 40, 1'b1);
    chk("busy while open", sawBusy, 1'b1);
    chk("open word kept", featureWord_ff, 16'h0000);
    $display("test open done");
  endtask

  // Blank write first, then a normal write back: the gap is the write-time saving
  task tSecured;
    cmd(3'h5, 8'h00, 16'h0001, HND);
    chkReply(1'b0, 16'h0001);
    chk("alarm on", featureWord_ff, 16'h0001);
    blank = lat;
    rdr.alarmCheck;
    #1;
    chk("select hit", selHit_ff, 1'b1);
    chk("alarm match", selMatch_ff, 1'b1);
    rdr.readWord;
    #1;
    chk("read hit", rdHit_ff, 1'b1);
    chk("read data", rdData_ff, 16'h0001);
    cmd(3'h5, 8'h00, 16'h0001, HND);
    chkReply(1'b0, 16'h0000);
    chk("blank write gain", lat - blank, WCYC - BCYC);
    rdr.alarmCheck;
    #1;
    chk("alarm no match", selMatch_ff, 1'b0);
    $display("test secured done");
  endtask

  task tHold;
    cmd(3'h5, 8'h00, 16'h0000, HND);
    chkReply(1'b0, 16'h0000);
    chk("zero toggle fast", lat <= 40, 1'b1);
    @(posedge core_clk);
    accessPwdNonzero <= 1'b0;
    cmd(3'h5, 8'h00, 16'h0001, HND);
    chkReply(1'b0, 16'h0000);
    chk("no password word", featureWord_ff, 16'h0000);
    @(posedge core_clk);
    accessPwdNonzero <= 1'b1;
    $display("test hold done");
  endtask

  task tIgnore;
    for (int s = 0; s < 7; s++)
    begin
      if (s == 4 || s == 5) continue;
      cmd(s[2:0], 8'h00, 16'h0001, HND);
      chk("no reply", lat, 0);
      chk("to arbitrate", sawArb, s >= 1 && s <= 3);
      chk("ignored idle", sawBusy, 1'b0);
    end
    cmd(3'h5, 8'h00, 16'h0001, ~HND);
    chk("bad handle silent", lat, 0);
    chk("bad handle word", featureWord_ff, 16'h0000);
    chk("bad handle idle", sawBusy, 1'b0);
    $display("test ignore done");
  endtask

  task tErrors;
    cmd(3'h5, 8'h01, 16'h0001, HND);
    chkReply(1'b1, 16'h0000);
    @(posedge core_clk);
    nvmFault <= 1'b1;
    cmd(3'h5, 8'h00, 16'h0001, HND);
    chkReply(1'b1, 16'h000F);
    chk("fault word kept", featureWord_ff, 16'h0000);
    @(posedge core_clk);
    nvmFault <= 1'b0;
    $display("test errors done");
  endtask

  task printVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Reset for six cycles, then run every scenario
  initial
  begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("word at reset", featureWord_ff, 16'h0000);
    chk("umi at reset", umiBit_ff, 1'b0);
    tSide;
    tOpen;
    tSecured;
    tHold;
    tIgnore;
    tErrors;
    printVerdict;
  end
endmodule
`default_nettype wire
